// file: logic/secondary_status_pkg.sv
// Constants, types and carriers for the secondary status register bank
package secondary_status_pkg;

    localparam int ADDR_W = 9;
    localparam logic [8:0] SECONDARY_STATUS_OFS = 9'h114;
    localparam logic [8:0] EXPBUS_TIMEOUT_OFS = 9'h118;

    // Bit positions inside the secondary status word
    localparam int PCI_REQUEST_PENDING_BIT = 31;
    localparam int PCI_MASTER_ACTIVE_BIT = 30;
    localparam int SEQ_TASK1_REG_ACCESS_ERR_BIT = 29;
    localparam int SEQ_TASK1_PAGE_ERR_BIT = 28;
    localparam int SEQ_TASK1_ACTIVE_BIT = 27;
    localparam int SEQ_TASK0_REG_ACCESS_ERR_BIT = 26;
    localparam int SEQ_TASK0_PAGE_ERR_BIT = 25;
    localparam int SEQ_TASK0_ACTIVE_BIT = 24;
    localparam int EXPBUS_TIMEOUT_FLAG_BIT = 23;
    localparam int EXPBUS_FORMAT_ERR_BIT = 22;
    localparam int TWOWIRE_ADDR_NACK_ERR_BIT = 21;
    localparam int TWOWIRE_FRAME_ERR_BIT = 17;
    localparam int VIDEO_DMA1_PROTECT_ERR_BIT = 14;
    localparam int VIDEO_FIFO3_FLOW_ERR_BIT = 13;

    // Reset values
    localparam logic [31:0] SECONDARY_STATUS_RESET = 32'h0080_0000;
    localparam logic [15:0] EXPBUS_TIMEOUT_RESET = 16'hFFFF;
    localparam logic [12:0] STATUS_LOW_RESERVED = 13'h0000;

    // Sequencer page size and doubleword size
    localparam int PAGE_SHIFT = 12;
    localparam logic [3:0] DWORD_BYTES = 4'h4;

    typedef enum logic [2:0] {
        CMD_OTHER = 3'h0,
        CMD_LOAD_REGISTER = 3'h1,
        CMD_STORE_REGISTER = 3'h2,
        CMD_MASKED_WRITE = 3'h3
    } seq_cmd_e;

    // One sequencer task as seen by the status bank
    typedef struct packed {
        logic start;          // Task started anew, pulse
        logic executing;      // Task running, level
        logic waiting;        // Waiting on a condition, level
        logic uploading;      // Uploading working registers, level
        logic cmd_strobe;     // Command decoded, pulse
        seq_cmd_e cmd_kind;
        logic target_exists;  // Addressed register exists
        logic wr_strobe;      // Task issues a write, pulse
        logic [31:0] wr_addr;
        logic [31:0] page_base;
    } seq_task_s;

    typedef struct packed {
        logic request;        // Request line asserted, level
        logic grant;          // Grant seen, level
        logic master;         // Acting as bus master, level
    } pci_s;

    typedef struct packed {
        logic start;          // New transfer, pulse
        logic busy;           // Transfer running, level
        logic imm_strobe;     // Immediate-mode command, pulse
        logic [1:0] imm_offset;
        logic [2:0] imm_length;
    } expbus_s;

    typedef struct packed {
        logic cmd_start;      // New two-wire command, pulse
        logic addr_nack;
        logic write_nack;
        logic read_nack;
        logic arb_lost;
        logic frame_err;
    } twowire_s;

    typedef struct packed {
        logic base_reload;            // Base address reload, pulse
        logic [3:1] active;           // Per channel transfer running
        logic [3:1][31:0] addr;
        logic [3:1][31:0] protect_addr;
        logic fifo3_flow;             // Fifo 3 over or underflow, pulse
    } video_s;

    // Write-one pulses from the interrupt status register
    typedef struct packed {
        logic seq_task1_error_summary;
        logic seq_task0_error_summary;
        logic expbus_event_summary;
        logic twowire_error_summary;
        logic video_protect_err_summary;
        logic video_fifo_err_summary;
    } isr_clear_s;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ANSWER = 2'b10
    } bus_state_e;

endpackage

// file: logic/secondary_status_regs.sv
// Secondary status register bank with an Avalon-MM slave port
//
// The Avalon-MM slave port is this design's own decision.
`timescale 1ns/1ps
module secondary_status_regs (
    input wire logic CLK_SYS,
    input wire logic RESET_N,
    input wire logic [8:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    input wire secondary_status_pkg::pci_s PCI,
    input wire secondary_status_pkg::seq_task_s SEQ_TASK1,
    input wire secondary_status_pkg::seq_task_s SEQ_TASK0,
    input wire secondary_status_pkg::expbus_s EXPBUS,
    input wire secondary_status_pkg::twowire_s TWOWIRE,
    input wire secondary_status_pkg::video_s VIDEO,
    input wire secondary_status_pkg::isr_clear_s ISR_CLEAR,
    output logic [31:0] SECONDARY_STATUS,
    output logic TWOWIRE_ERROR_SUMMARY
);

    logic [1:0] rst_sync_q;
    logic rst_n;
    logic [31:0] status_q;
    logic [31:0] sticky_set;
    logic [31:0] sticky_clr;
    logic [31:0] sticky_mask;
    logic [15:0] timeout_q;
    logic [15:0] exp_count_q;
    logic twowire_summary_q;
    logic [31:0] readdata_q;
    logic waitrequest_q;
    secondary_status_pkg::bus_state_e bus_q;
    logic req;
    logic done;
    logic hit_status;
    logic hit_timeout;
    logic task1_reg_err;
    logic task0_reg_err;
    logic task1_page_err;
    logic task0_page_err;
    logic exp_timeout_hit;
    logic exp_format_err;
    logic [3:1] dma_protect_err;
    logic first_q;

    // Reset release through two flops; assertion stays asynchronous
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // Bus decode; only whole aligned words are mapped
    assign req = AVS_READ | AVS_WRITE;
    assign done = req & ~waitrequest_q;
    assign hit_status = AVS_ADDRESS == secondary_status_pkg::SECONDARY_STATUS_OFS;
    assign hit_timeout = AVS_ADDRESS == secondary_status_pkg::EXPBUS_TIMEOUT_OFS;

    // Sequencer error detection per task
    function automatic logic reg_access_err(input secondary_status_pkg::seq_task_s t);
        logic hit_cmd;
        hit_cmd = (t.cmd_kind == secondary_status_pkg::CMD_LOAD_REGISTER) ||
                  (t.cmd_kind == secondary_status_pkg::CMD_STORE_REGISTER) ||
                  (t.cmd_kind == secondary_status_pkg::CMD_MASKED_WRITE);
        return t.cmd_strobe & hit_cmd & ~t.target_exists;
    endfunction

    // Page check compares everything above the page offset
    function automatic logic page_err(input secondary_status_pkg::seq_task_s t);
        logic outside;
        outside = t.wr_addr[31:secondary_status_pkg::PAGE_SHIFT] !=
                  t.page_base[31:secondary_status_pkg::PAGE_SHIFT];
        return t.wr_strobe & outside;
    endfunction

    assign task1_reg_err = reg_access_err(SEQ_TASK1);
    assign task0_reg_err = reg_access_err(SEQ_TASK0);
    assign task1_page_err = page_err(SEQ_TASK1);
    assign task0_page_err = page_err(SEQ_TASK0);

    // Immediate command must stay inside one doubleword
    assign exp_format_err = EXPBUS.imm_strobe &
        (({2'h0, EXPBUS.imm_offset} + {1'b0, EXPBUS.imm_length}) >
         secondary_status_pkg::DWORD_BYTES);

    // Expansion bus timeout counter; saturates so the flag is not missed
    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            exp_count_q <= 16'h0000;
        end else if (EXPBUS.start) begin
            exp_count_q <= 16'h0000;
        end else if (EXPBUS.busy && exp_count_q != 16'hFFFF) begin
            exp_count_q <= exp_count_q + 16'h0001;
        end
    end
    assign exp_timeout_hit = EXPBUS.busy & (exp_count_q == timeout_q);

    // Address past the protection address while the channel runs
    genvar ch;
    generate
        for (ch = 1; ch <= 3; ch++) begin : g_protect
            assign dma_protect_err[ch] = VIDEO.active[ch] &
                (VIDEO.addr[ch] > VIDEO.protect_addr[ch]);
        end
    endgenerate

    // Set vector of the sticky bits
    always_comb begin
        sticky_set = 32'h0000_0000;
        sticky_set[29] = task1_reg_err;
        sticky_set[28] = task1_page_err;
        sticky_set[26] = task0_reg_err;
        sticky_set[25] = task0_page_err;
        sticky_set[23] = exp_timeout_hit;
        sticky_set[22] = exp_format_err;
        sticky_set[21] = TWOWIRE.addr_nack;
        sticky_set[20] = TWOWIRE.write_nack;
        sticky_set[19] = TWOWIRE.read_nack;
        sticky_set[18] = TWOWIRE.arb_lost;
        sticky_set[17] = TWOWIRE.frame_err;
        sticky_set[16:14] = dma_protect_err;
        sticky_set[13] = VIDEO.fifo3_flow;
    end

    // Clear vector; expansion bus flags clear only through the summary write
    always_comb begin
        sticky_clr = 32'h0000_0000;
        sticky_clr[29:28] = {2{ISR_CLEAR.seq_task1_error_summary | SEQ_TASK1.start}};
        sticky_clr[26:25] = {2{ISR_CLEAR.seq_task0_error_summary | SEQ_TASK0.start}};
        sticky_clr[23:22] = {2{ISR_CLEAR.expbus_event_summary}};
        sticky_clr[21:17] = {5{ISR_CLEAR.twowire_error_summary | TWOWIRE.cmd_start}};
        sticky_clr[16:14] = {3{ISR_CLEAR.video_protect_err_summary | VIDEO.base_reload}};
        sticky_clr[13] = ISR_CLEAR.video_fifo_err_summary | VIDEO.base_reload;
    end

    assign sticky_mask = 32'h36FF_E000;

    // Sticky bits: a set in the clearing cycle wins; the bus never writes here
    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            status_q <= secondary_status_pkg::SECONDARY_STATUS_RESET;
        end else begin
            status_q <= ((status_q & ~sticky_clr) | sticky_set) & sticky_mask;
            status_q[31] <= PCI.request & ~PCI.grant;
            status_q[30] <= PCI.master;
            status_q[27] <= SEQ_TASK1.executing & ~SEQ_TASK1.waiting &
                            ~SEQ_TASK1.uploading;
            status_q[24] <= SEQ_TASK0.executing & ~SEQ_TASK0.waiting &
                            ~SEQ_TASK0.uploading;
        end
    end

    // Two-wire summary: set by the error bits, held until a new transfer drops it
    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            twowire_summary_q <= 1'b0;
        end else begin
            // Start masks the old bits too, else the summary never drops
            twowire_summary_q <= (twowire_summary_q | (|status_q[21:17])) &
                                 ~TWOWIRE.cmd_start;
        end
    end

    // Timeout register, the only writable state; byte lanes honoured
    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            timeout_q <= secondary_status_pkg::EXPBUS_TIMEOUT_RESET;
        end else if (AVS_WRITE && done && hit_timeout) begin
            if (AVS_BYTEENABLE[0]) begin
                timeout_q[7:0] <= AVS_WRITEDATA[7:0];
            end
            if (AVS_BYTEENABLE[1]) begin
                timeout_q[15:8] <= AVS_WRITEDATA[15:8];
            end
        end
    end

    // One wait state: read data is captured while waitrequest is high
    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            bus_q <= secondary_status_pkg::BUS_IDLE;
            waitrequest_q <= 1'b1;
        end else begin
            case (bus_q)
                secondary_status_pkg::BUS_IDLE: begin
                    if (req) begin
                        bus_q <= secondary_status_pkg::BUS_ANSWER;
                        waitrequest_q <= 1'b0;
                    end
                end
                secondary_status_pkg::BUS_ANSWER: begin
                    bus_q <= secondary_status_pkg::BUS_IDLE;
                    waitrequest_q <= 1'b1;
                end
                default: begin
                    bus_q <= secondary_status_pkg::BUS_IDLE;
                    waitrequest_q <= 1'b1;
                end
            endcase
        end
    end

    // Read mux; unmapped addresses read zero
    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            readdata_q <= 32'h0000_0000;
        end else if (AVS_READ && waitrequest_q) begin
            if (hit_status) begin
                readdata_q <= status_q;
            end else if (hit_timeout) begin
                readdata_q <= {16'h0000, timeout_q};
            end else begin
                readdata_q <= 32'h0000_0000;
            end
        end
    end

    assign AVS_READDATA = readdata_q;
    assign AVS_WAITREQUEST = waitrequest_q;
    assign SECONDARY_STATUS = status_q;
    assign TWOWIRE_ERROR_SUMMARY = twowire_summary_q;

    // Marks the first cycle out of reset for the reset-value check
    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            first_q <= 1'b1;
        end else begin
            first_q <= 1'b0;
        end
    end

    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!rst_n);

    chk_pci_request_pending: assert property (
        ##1 status_q[31] == $past(PCI.request & ~PCI.grant))
        else $error("request pending bit does not track request without grant");

    chk_pci_master_bit: assert property (
        PCI.master ##1 PCI.master |-> ##1 status_q[30] ##0 $past(status_q[30]))
        else $error("master bit not held while master");

    chk_task1_reg_set: assert property (
        task1_reg_err |=> status_q[29])
        else $error("task 1 register error not latched");

    chk_task1_page_set: assert property (
        SEQ_TASK1.wr_strobe && SEQ_TASK1.wr_addr[31:12] != SEQ_TASK1.page_base[31:12]
        |=> status_q[28])
        else $error("task 1 page error not latched");

    chk_task1_active_bit: assert property (
        SEQ_TASK1.waiting || SEQ_TASK1.uploading |=> !status_q[27])
        else $error("task 1 active while waiting or uploading");

    chk_task0_err_clear: assert property (
        SEQ_TASK0.start && !task0_reg_err && !task0_page_err |=> !status_q[26] && !status_q[25])
        else $error("task 0 errors survive a restart");

    chk_task0_page_set: assert property (
        task0_page_err ##1 (!SEQ_TASK0.start && !ISR_CLEAR.seq_task0_error_summary) [*2]
        |-> status_q[25])
        else $error("task 0 page error lost");

    chk_task0_active_bit: assert property (
        SEQ_TASK0.executing && !SEQ_TASK0.waiting && !SEQ_TASK0.uploading |=> status_q[24])
        else $error("task 0 active bit missing");

    chk_expbus_timeout_hold: assert property (
        status_q[23] && !ISR_CLEAR.expbus_event_summary |=> status_q[23])
        else $error("timeout flag dropped without its clear");

    chk_timeout_after_reset: assert property (
        first_q |-> status_q[23])
        else $error("timeout flag not one after reset");

    chk_expbus_format_set: assert property (
        EXPBUS.imm_strobe && (EXPBUS.imm_offset + EXPBUS.imm_length > 4) |=> status_q[22])
        else $error("format error not latched");

    chk_twowire_errors: assert property (
        TWOWIRE.addr_nack || TWOWIRE.frame_err |=> status_q[21] || status_q[17])
        else $error("two-wire error not latched");

    chk_twowire_restart: assert property (
        TWOWIRE.cmd_start && !(|sticky_set[21:17]) |=> status_q[21:17] == 5'h00)
        else $error("two-wire errors survive a new command");

    chk_twowire_summary: assert property (
        |status_q[21:17] && !TWOWIRE.cmd_start |=> twowire_summary_q)
        else $error("two-wire summary not set by an error bit");

    chk_video_protect: assert property (
        VIDEO.active[3] && VIDEO.addr[3] > VIDEO.protect_addr[3] |=> status_q[16])
        else $error("channel 3 protection error not latched");

    chk_video_fifo_clear: assert property (
        VIDEO.base_reload && !VIDEO.fifo3_flow |=> !status_q[13])
        else $error("fifo 3 flag survives a base reload");

    chk_status_write_ignored: assert property (
        AVS_WRITE && done && hit_status && sticky_set == 32'h0 && sticky_clr == 32'h0
        |=> status_q[29:13] == $past(status_q[29:13]) || $past(status_q[27]) != status_q[27]
            || $past(status_q[24]) != status_q[24])
        else $error("bus write changed a sticky bit");

    chk_bus_one_wait: assert property (
        req && waitrequest_q |=> !waitrequest_q ##1 waitrequest_q)
        else $error("bus answer not after exactly one wait state");

endmodule

// file: verification/secondary_status_regs_tb.sv
// Self-checking bench for the secondary status register bank
`timescale 1ns/1ps
module secondary_status_regs_tb;
    logic clk_sys = 1'h0;
    logic reset_n = 1'h0;
    logic [8:0] avs_address = 9'h000;
    logic avs_read = 1'h0;
    logic avs_write = 1'h0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [31:0] status_w;
    logic tw_sum;
    secondary_status_pkg::pci_s pci = '0;
    secondary_status_pkg::seq_task_s sq [2] = '{default: '0};
    secondary_status_pkg::expbus_s ex = '0;
    secondary_status_pkg::twowire_s tw = '0;
    secondary_status_pkg::video_s vid = '0;
    secondary_status_pkg::isr_clear_s interrupt_status_reg = '0;
    int err_total = 0;
    int tests_run = 0;
    logic [31:0] st_exp;
    logic [31:0] rd;

    // 50 MHz system clock
    always #10 clk_sys = ~clk_sys;

    secondary_status_regs dut_u (
        .CLK_SYS(clk_sys), .RESET_N(reset_n), .AVS_ADDRESS(avs_address),
        .AVS_READ(avs_read), .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata),
        .AVS_BYTEENABLE(4'hF), .AVS_READDATA(avs_readdata),
        .AVS_WAITREQUEST(avs_waitrequest), .PCI(pci), .SEQ_TASK1(sq[1]),
        .SEQ_TASK0(sq[0]), .EXPBUS(ex), .TWOWIRE(tw), .VIDEO(vid), .ISR_CLEAR(interrupt_status_reg),
        .SECONDARY_STATUS(status_w), .TWOWIRE_ERROR_SUMMARY(tw_sum)
    );

    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t %s: got %h expected %h", $time, msg, got, exp);
        end
    endtask

    task automatic chk_st(input string msg);
        chk(status_w, st_exp, msg);
    endtask

    // One Avalon access; request held until waitrequest is seen low at an edge
    task automatic bus(input logic wr, input logic [8:0] addr, input logic [31:0] wdata,
                       output logic [31:0] rdata);
        int n;
        n = 0;
        @(posedge clk_sys);
        avs_address <= addr;
        avs_writedata <= wdata;
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge clk_sys);
            n++;
        end while (avs_waitrequest !== 1'h0 && n < 20);
        rdata = avs_readdata;
        avs_read <= 1'h0;
        avs_write <= 1'h0;
        if (n >= 20) begin
            err_total++;
            $display("[FAIL] %0t bus access never answered", $time);
            test_done();
        end
    endtask

    // One-cycle event on a chosen source, then settle two edges
    task automatic pulse(input int w);
        @(posedge clk_sys);
        case (w)
            0: interrupt_status_reg.seq_task0_error_summary <= 1'h1;
            1: interrupt_status_reg.seq_task1_error_summary <= 1'h1;
            2: interrupt_status_reg.expbus_event_summary <= 1'h1;
            3: interrupt_status_reg.twowire_error_summary <= 1'h1;
            4: interrupt_status_reg.video_protect_err_summary <= 1'h1;
            5: interrupt_status_reg.video_fifo_err_summary <= 1'h1;
            6: sq[0].start <= 1'h1;
            7: sq[1].start <= 1'h1;
            8: tw.cmd_start <= 1'h1;
            9: vid.base_reload <= 1'h1;
            10: tw.addr_nack <= 1'h1;
            11: tw.write_nack <= 1'h1;
            12: tw.read_nack <= 1'h1;
            13: tw.arb_lost <= 1'h1;
            14: tw.frame_err <= 1'h1;
            15: vid.fifo3_flow <= 1'h1;
            default: ex.start <= 1'h1;
        endcase
        @(posedge clk_sys);
        interrupt_status_reg <= '0;
        sq[0].start <= 1'h0;
        sq[1].start <= 1'h0;
        tw <= '0;
        vid.base_reload <= 1'h0;
        vid.fifo3_flow <= 1'h0;
        ex.start <= 1'h0;
        tick(1);
        #1;
    endtask

    // Sequencer command (cmd=1) or write (cmd=0) on task t
    task automatic seq_op(input int t, input logic cmd, input int k, input logic found,
                          input logic [31:0] wa);
        @(posedge clk_sys);
        sq[t].cmd_strobe <= cmd;
        sq[t].cmd_kind <= secondary_status_pkg::seq_cmd_e'(k);
        sq[t].target_exists <= found;
        sq[t].wr_strobe <= !cmd;
        sq[t].wr_addr <= wa;
        @(posedge clk_sys);
        sq[t].cmd_strobe <= 1'h0;
        sq[t].wr_strobe <= 1'h0;
        tick(1);
        #1;
    endtask

    task automatic t_reset();
        @(posedge clk_sys);
        reset_n <= 1'h0;
        tick(4);
        reset_n <= 1'h1;
        tick(5);
        #1;
        st_exp = 32'h0080_0000;
        chk_st("status after reset");
        bus(1'h0, 9'h114, 32'h0, rd);
        chk(rd, 32'h0080_0000, "status read after reset");
        chk({31'h0, tw_sum}, 32'h0, "summary after reset");
        bus(1'h0, 9'h118, 32'h0, rd);
        chk(rd & 32'h0000_FFFF, 32'h0000_FFFF, "timeout after reset");
        bus(1'h0, 9'h1F0, 32'h0, rd);
        chk(rd, 32'h0, "unmapped read");
    endtask

    // Live bits follow every combination; tasks get opposite patterns
    task automatic t_live();
        logic [2:0] a;
        logic [2:0] b;
        logic [31:0] e;
        for (int i = 0; i < 8; i++) begin
            a = i[2:0];
            b = 3'h7 - a;
            @(posedge clk_sys);
            pci <= '{request: a[2], grant: a[1], master: a[0]};
            sq[0].executing <= a[2];
            sq[0].waiting <= a[1];
            sq[0].uploading <= a[0];
            sq[1].executing <= b[2];
            sq[1].waiting <= b[1];
            sq[1].uploading <= b[0];
            tick(2);
            #1;
            e = st_exp;
            e[31] = a[2] & ~a[1];
            e[30] = a[0];
            e[27] = b[2] & ~b[1] & ~b[0];
            e[24] = a[2] & ~a[1] & ~a[0];
            chk(status_w, e, "live bits");
        end
        @(posedge clk_sys);
        pci <= '0;
        sq[0].executing <= 1'h0;
        sq[1].executing <= 1'h0;
        tick(2);
    endtask

    task automatic t_seq();
        int re;
        int pe;
        for (int t = 0; t < 2; t++) begin
            re = (t == 1) ? 29 : 26;
            pe = (t == 1) ? 28 : 25;
            @(posedge clk_sys);
            sq[t].page_base <= 32'h0001_2000;
            seq_op(t, 1'h1, 0, 1'h0, 32'h0);
            seq_op(t, 1'h1, 1, 1'h1, 32'h0);
            chk_st("no access error expected");
            for (int k = 1; k < 4; k++) begin
                seq_op(t, 1'h1, k, 1'h0, 32'h0);
                st_exp[re] = 1'h1;
                chk_st("access error set");
                pulse((k == 2) ? 6 + t : t);
                st_exp[re] = 1'h0;
                chk_st("access error cleared");
            end
            seq_op(t, 1'h0, 0, 1'h1, 32'h0001_2FFC);
            chk_st("write at page end");
            seq_op(t, 1'h0, 0, 1'h1, 32'h0001_3000);
            st_exp[pe] = 1'h1;
            chk_st("page error set");
            pulse(6 + t);
            st_exp[pe] = 1'h0;
            chk_st("page error cleared by start");
            seq_op(t, 1'h0, 0, 1'h1, 32'h0001_1FFC);
            st_exp[pe] = 1'h1;
            chk_st("page error below page");
        end
        pulse(1);
        st_exp[28] = 1'h0;
        chk_st("task 1 clear spares task 0");
        pulse(0);
        st_exp[25] = 1'h0;
        chk_st("task 0 clear");
    endtask

    task automatic imm(input logic [1:0] ofs, input logic [2:0] len);
        @(posedge clk_sys);
        ex.imm_strobe <= 1'h1;
        ex.imm_offset <= ofs;
        ex.imm_length <= len;
        @(posedge clk_sys);
        ex.imm_strobe <= 1'h0;
        tick(1);
        #1;
    endtask

    task automatic t_exp();
        int n;
        pulse(2);
        st_exp[23] = 1'h0;
        chk_st("timeout flag cleared");
        imm(2'h2, 3'h2);
        chk_st("fits in doubleword");
        imm(2'h3, 3'h2);
        st_exp[22] = 1'h1;
        chk_st("crosses doubleword");
        bus(1'h1, 9'h118, 32'h0000_0006, rd);
        bus(1'h0, 9'h118, 32'h0, rd);
        chk(rd, 32'h0000_0006, "timeout readback");
        ex.busy <= 1'h1;
        pulse(16);
        chk_st("no timeout yet");
        n = 0;
        while (status_w[23] !== 1'h1 && n < 40) begin
            tick(1);
            #1;
            n++;
        end
        st_exp[23] = 1'h1;
        chk_st("timeout reached");
        chk(n, 32'h0000_0006, "timeout cycle count");
        if (n >= 40) begin
            test_done();
        end
        @(posedge clk_sys);
        ex.busy <= 1'h0;
        pulse(16);
        chk_st("start keeps event flags");
        pulse(2);
        st_exp[23] = 1'h0;
        st_exp[22] = 1'h0;
        chk_st("event flags cleared");
    endtask

    task automatic t_tw();
        for (int w = 10; w < 15; w++) begin
            pulse(w);
            st_exp[31 - w] = 1'h1;
            chk_st("two-wire error set");
            chk({31'h0, tw_sum}, 32'h1, "summary set");
            pulse(3);
            st_exp[31 - w] = 1'h0;
            chk_st("two-wire error cleared");
            chk({31'h0, tw_sum}, 32'h1, "summary held");
            pulse(w);
            pulse(8);
            chk_st("cleared by new command");
            chk({31'h0, tw_sum}, 32'h0, "summary cleared");
        end
    endtask

    task automatic t_video();
        for (int ch = 1; ch < 4; ch++) begin
            @(posedge clk_sys);
            vid.protect_addr[ch] <= 32'h0000_8000;
            vid.addr[ch] <= 32'h0000_8001;
            tick(3);
            #1;
            chk_st("idle channel beyond limit");
            @(posedge clk_sys);
            vid.addr[ch] <= 32'h0000_8000;
            vid.active[ch] <= 1'h1;
            tick(3);
            #1;
            chk_st("address at limit");
            @(posedge clk_sys);
            vid.addr[ch] <= 32'h0000_8001;
            tick(3);
            #1;
            st_exp[ch + 13] = 1'h1;
            chk_st("protection error set");
            @(posedge clk_sys);
            vid.active <= 3'h0;
            pulse((ch == 1) ? 4 : 9);
            st_exp[ch + 13] = 1'h0;
            chk_st("protection error cleared");
        end
        pulse(15);
        st_exp[13] = 1'h1;
        pulse(4);
        chk_st("fifo flag kept");
        pulse(5);
        st_exp[13] = 1'h0;
        chk_st("fifo flag cleared");
        pulse(15);
        pulse(9);
        chk_st("fifo flag cleared by reload");
    endtask

    // Writes leave the word alone; bits 21 and 13 stay set through the writes
    task automatic t_wr();
        pulse(10);
        pulse(15);
        st_exp[21] = 1'h1;
        st_exp[13] = 1'h1;
        bus(1'h1, 9'h114, 32'h0, rd);
        bus(1'h1, 9'h114, 32'hFFFF_FFFF, rd);
        bus(1'h1, 9'h1F0, 32'hFFFF_FFFF, rd);
        bus(1'h0, 9'h114, 32'h0, rd);
        chk(rd, st_exp, "status after writes");
        #1;
        chk_st("status port after writes");
    endtask

    initial begin
        t_reset();
        t_live();
        t_seq();
        t_exp();
        t_tw();
        t_video();
        t_wr();
        t_reset();
        test_done();
    end
endmodule
